// *** hw/ccpcs_top.sv ***
// core control registers, program counter and return stack
//
// Contract
// - prescaler goes to timer or watchdog; watchdog-assigned means timer counts 1:1.
// - rate code n divides timer by 2^(n+1), watchdog by 2^n.
// - flags set on their condition regardless of any enable bit.
// - interrupt taken only with global enable and source enable both one.
// - converter interrupt additionally gated by the peripheral enable bit.
// - timer overflow flag set on overflow, held until software writes zero.
// - external flag set on selected pin edge, held until software clears.
// - port change flag set when any of three pins changes, held.
// - converter done sets flag bit 6; enable bit 6 enables it.
// - power-on status bit cleared only by power-on reset.
// - oscillator gets four-bit fine trim in bits 7:4, faster and slower.
// - with faster and slower both set, only faster acts.
// - 13-bit program counter; low byte is a register, upper bits hidden.
// - whole program counter cleared by every reset; the code clears it on presetn only, not on por_rstn.
// - low byte write loads upper counter bits from latch bits 4:0.
// - call and jump targets from address field; latch bits 4:3 ignored.
// - adding to the low byte never carries into upper counter bits.
// - eight-entry 13-bit return stack, pointer not visible to software.
// - push on call and interrupt vector; pop on all three returns.
// - pushes and pops leave the high holding latch untouched.
// - stack is circular, no overflow or underflow status.
`timescale 1ns/1ps
`include "ccpcs_regs.svh"
module ccpcs_top
  import ccpcs_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        por_rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  ccpcs_core_s      core_cmd,
  input  wire logic        instr_tick,
  input  wire logic        wdt_tick,
  input  wire logic        ext_interrupt_pin,
  input  wire logic [2:0]  change_pins,
  input  wire logic        timer_overflow,
  input  wire logic        conv_done,
  output logic      [12:0] pc_q,
  output logic             int_taken_q,
  output logic             timer_inc_q,
  output logic             wdt_inc_q,
  output logic             pullup_disable_q,
  output ccpcs_trim_s      trim_q
);
  // ****************************************
  // apb decode
  // ****************************************
  logic [7:0]   intc_q;
  logic         conv_flag_q;
  logic [7:0]   opt_q;
  logic         conv_en_q;
  logic         por_q;
  logic [5:0]   osc_q;
  logic [4:0]   latch_q;
  logic [31:0]  prdata_q;
  logic         pready_q;
  logic         pslverr_q;
  logic         xpin_q;
  logic [2:0]   chg_q;
  logic [2:0]   sp_q;
  logic [2:0]   sp_d;
  logic [12:0]  pc_d;
  logic [12:0]  stk_rdata;
  ccpcs_state_e st_q;
  ccpcs_state_e st_d;
  logic         tmr_inc;
  logic         wd_inc;

  wire [7:0] idx    = paddr[9:2];
  wire       setup  = psel & ~penable;
  wire       access = psel & penable & pready_q;
  wire       wr     = access & pwrite;
  wire [7:0] wd     = pwdata[7:0];
  wire       hit_pcl  = (idx == `CCPCS_IDX_PCL) | (idx == `CCPCS_IDX_ALT0);
  wire       hit_pch  = (idx == `CCPCS_IDX_PCH) | (idx == `CCPCS_IDX_ALT1);
  wire       hit_intc = (idx == `CCPCS_IDX_INTC) | (idx == `CCPCS_IDX_ALT2);
  wire       hit_pflg = idx == `CCPCS_IDX_PFLG;
  wire       hit_opt  = idx == `CCPCS_IDX_OPT;
  wire       hit_pen  = idx == `CCPCS_IDX_PEN;
  wire       hit_pwr  = idx == `CCPCS_IDX_PWR;
  wire       hit_trim = idx == `CCPCS_IDX_TRIM;
  wire       mapped   = (paddr[11:10] == 2'h0) & (hit_pcl | hit_pch | hit_intc | hit_pflg |
                        hit_opt | hit_pen | hit_pwr | hit_trim);
  wire       wr_ok    = wr & ~pslverr_q;

  wire [7:0] rd_mux =
      hit_pcl  ? pc_q[7:0] :
      hit_pch  ? {3'h0, latch_q} :
      hit_intc ? intc_q :
      hit_pflg ? {1'b0, conv_flag_q, 6'h00} :
      hit_opt  ? opt_q :
      hit_pen  ? {1'b0, conv_en_q, 6'h00} :
      hit_pwr  ? {6'h00, por_q, 1'b0} :
      hit_trim ? {osc_q, 2'h0} : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup) prdata_q <= mapped ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ****************************************
  // pin events and prescaler
  // ****************************************
  wire xrise = ext_interrupt_pin & ~xpin_q;
  wire xfall = ~ext_interrupt_pin & xpin_q;
  // 1 selects rising edge for the interrupt
  wire x_ev  = opt_q[`CCPCS_B_XEDGE] ? xrise : xfall;
  // timer source edge 1 counts high-to-low
  wire t_pin = opt_q[`CCPCS_B_TSE] ? xfall : xrise;
  wire t_ev  = opt_q[`CCPCS_B_TCS] ? t_pin : instr_tick;
  wire c_ev  = |(change_pins ^ chg_q);

  ccpcs_prescaler u_pre (
    .pclk             (pclk),
    .presetn          (presetn),
    .timer_ev         (t_ev),
    .wdt_ev           (wdt_tick),
    .prescaler_assign (opt_q[`CCPCS_B_PSA]),
    .prescale_rate    (opt_q[`CCPCS_F_RATE]),
    .timer_inc        (tmr_inc),
    .wdt_inc          (wd_inc)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xpin_q      <= 1'b0;
      chg_q       <= 3'h0;
      timer_inc_q <= 1'b0;
      wdt_inc_q   <= 1'b0;
    end else begin
      xpin_q      <= ext_interrupt_pin;
      chg_q       <= change_pins;
      timer_inc_q <= tmr_inc;
      wdt_inc_q   <= wd_inc;
    end
  end

  // ****************************************
  // interrupt control and flags
  // ****************************************
  wire   run  = st_q == CCPCS_RUN;
  wire   pend_per = intc_q[`CCPCS_B_PERIPHERAL_INT_ENABLE] & conv_en_q & conv_flag_q;
  wire   pend = intc_q[`CCPCS_B_GIE] & (
                (intc_q[`CCPCS_B_T0IE] & intc_q[`CCPCS_B_TIMER_OVERFLOW_FLAG]) |
                (intc_q[`CCPCS_B_XIE] & intc_q[`CCPCS_B_XIF]) |
                (intc_q[`CCPCS_B_PCIE] & intc_q[`CCPCS_B_PCIF]) | pend_per);
  // interrupts are only taken between instructions, never under a branch
  wire   take = pend & run & core_cmd.step & ~core_cmd.call & ~core_cmd.jump & ~core_cmd.ret;
  wire   do_ret = run & core_cmd.ret;

  wire       wr_intc = wr_ok & hit_intc;
  wire [7:0] intc_w  = wr_intc ? wd : intc_q;
  logic [7:0] intc_d;

  always_comb begin
    intc_d = intc_w;
    // set wins over a software clear in the same cycle
    if (timer_overflow) intc_d[`CCPCS_B_TIMER_OVERFLOW_FLAG] = 1'b1;
    if (x_ev) intc_d[`CCPCS_B_XIF] = 1'b1;
    if (c_ev) intc_d[`CCPCS_B_PCIF] = 1'b1;
    if (take) intc_d[`CCPCS_B_GIE] = 1'b0;
    else if (do_ret & core_cmd.return_from_int_instr) intc_d[`CCPCS_B_GIE] = 1'b1;
  end

  wire conv_d = conv_done | ((wr_ok & hit_pflg) ? wd[`CCPCS_B_CONV] : conv_flag_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intc_q      <= 8'h00;
      conv_flag_q <= 1'b0;
      conv_en_q   <= 1'b0;
      opt_q       <= `CCPCS_RST_OPT;
      osc_q       <= `CCPCS_RST_TRIM;
      latch_q     <= 5'h00;
      int_taken_q <= 1'b0;
    end else begin
      intc_q      <= intc_d;
      conv_flag_q <= conv_d;
      int_taken_q <= take;
      if (wr_ok & hit_pen) conv_en_q <= wd[`CCPCS_B_CONV];
      if (wr_ok & hit_opt) opt_q <= wd;
      if (wr_ok & hit_trim) osc_q <= wd[`CCPCS_F_TRIM];
      // only software reaches the latch; stack traffic leaves it alone
      if (wr_ok & hit_pch) latch_q <= wd[`CCPCS_F_LATCH];
    end
  end

  // power-on flag lives on its own reset so other resets keep it
  always_ff @(posedge pclk or negedge por_rstn) begin
    if (!por_rstn) por_q <= 1'b0;
    else if (wr_ok & hit_pwr) por_q <= wd[`CCPCS_B_POR];
  end

  // ****************************************
  // configuration outputs
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_disable_q <= 1'b1;
      trim_q           <= '0;
    end else begin
      pullup_disable_q <= opt_q[`CCPCS_B_PUD];
      // stored trim drops the two unused low bits, so fields sit two places down
      trim_q.fine      <= osc_q[`CCPCS_F_FINE_Q];
      trim_q.faster    <= osc_q[`CCPCS_B_FAST - 2];
      trim_q.slower    <= osc_q[`CCPCS_B_SLOW - 2] & ~osc_q[`CCPCS_B_FAST - 2];
    end
  end

  // ****************************************
  // program counter and stack
  // ****************************************
  wire        push    = take | (run & core_cmd.call);
  wire [12:0] pc_inc  = pc_q + 13'h0001;
  wire [12:0] push_pc = take ? pc_q : pc_inc;
  wire [12:0] jmp_pc  = {`CCPCS_PAGE_TOP, core_cmd.target};
  wire [2:0]  sp_dec  = sp_q - 3'h1;

  ccpcs_stack_mem u_stk (
    .pclk    (pclk),
    .we      (push),
    .waddr   (sp_q),
    .wdata   (push_pc),
    .raddr   (sp_dec),
    .rdata_q (stk_rdata)
  );

  always_comb begin
    pc_d = pc_q;
    sp_d = sp_q;
    st_d = st_q;
    case (st_q)
      CCPCS_RUN: begin
        if (wr_ok & hit_pcl) begin
          // 8-bit write, so an added offset wraps inside the block
          pc_d = {latch_q, wd};
        end else if (take) begin
          pc_d = `CCPCS_INT_VEC;
          sp_d = sp_q + 3'h1;
        end else if (core_cmd.call) begin
          pc_d = jmp_pc;
          sp_d = sp_q + 3'h1;
        end else if (core_cmd.jump) begin
          pc_d = jmp_pc;
        end else if (core_cmd.ret) begin
          sp_d = sp_dec;
          st_d = CCPCS_POP;
        end else if (core_cmd.step) begin
          pc_d = pc_inc;
        end
      end
      CCPCS_POP: begin
        pc_d = stk_rdata;
        st_d = CCPCS_RUN;
      end
      default: st_d = CCPCS_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q     <= 13'h0000;
      sp_q     <= 3'h0;
      st_q     <= CCPCS_RUN;
    end else begin
      pc_q     <= pc_d;
      sp_q     <= sp_d;
      st_q     <= st_d;
    end
  end
endmodule : ccpcs_top

// *** hw/ccpcs_regs.svh ***
// register indices, field positions, reset values and fixed counts
`ifndef CCPCS_REGS_SVH
`define CCPCS_REGS_SVH
// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define CCPCS_IDX_PCL    8'h02
`define CCPCS_IDX_PCH    8'h0a
`define CCPCS_IDX_INTC   8'h0b
`define CCPCS_IDX_PFLG   8'h0c
`define CCPCS_IDX_OPT    8'h81
`define CCPCS_IDX_PEN    8'h8c
`define CCPCS_IDX_PWR    8'h8e
`define CCPCS_IDX_TRIM   8'h8f
`define CCPCS_IDX_ALT0   8'h82
`define CCPCS_IDX_ALT1   8'h8a
`define CCPCS_IDX_ALT2   8'h8b
// ****************************************
// field positions
// ****************************************
`define CCPCS_B_GIE      7
`define CCPCS_B_PERIPHERAL_INT_ENABLE     6
`define CCPCS_B_T0IE     5
`define CCPCS_B_XIE      4
`define CCPCS_B_PCIE     3
`define CCPCS_B_TIMER_OVERFLOW_FLAG     2
`define CCPCS_B_XIF      1
`define CCPCS_B_PCIF     0
`define CCPCS_B_CONV     6
`define CCPCS_B_POR      1
`define CCPCS_B_PUD      7
`define CCPCS_B_XEDGE    6
`define CCPCS_B_TCS      5
`define CCPCS_B_TSE      4
`define CCPCS_B_PSA      3
`define CCPCS_F_RATE     2:0
`define CCPCS_F_FINE     7:4
`define CCPCS_F_FINE_Q   5:2
`define CCPCS_B_FAST     3
`define CCPCS_B_SLOW     2
`define CCPCS_F_TRIM     7:2
`define CCPCS_F_LATCH    4:0
// ****************************************
// reset values and constants
// ****************************************
`define CCPCS_RST_OPT    8'hff
`define CCPCS_RST_TRIM   6'h1c
`define CCPCS_INT_VEC    13'h0004
`define CCPCS_PAGE_TOP   2'h0
`define CCPCS_STK_DEPTH  8
`endif

// *** hw/ccpcs_pkg.sv ***
// types shared by the core control block
package ccpcs_pkg;
  typedef struct packed {
    logic        step;
    logic        call;
    logic        jump;
    logic        ret;
    logic        return_from_int_instr;
    logic [10:0] target;
  } ccpcs_core_s;

  typedef struct packed {
    logic [3:0] fine;
    logic       faster;
    logic       slower;
  } ccpcs_trim_s;

  typedef enum logic [0:0] {
    CCPCS_RUN,
    CCPCS_POP
  } ccpcs_state_e;

  function automatic logic [7:0] ccpcs_mask(input logic [2:0] rate, input logic extra);
    logic [8:0] m;
    m = (9'h001 << ({1'b0, rate} + {3'h0, extra})) - 9'h001;
    return m[7:0];
  endfunction : ccpcs_mask
endpackage : ccpcs_pkg

// *** hw/ccpcs_prescaler.sv ***
// shared timer / watchdog prescaler
`timescale 1ns/1ps
`include "ccpcs_regs.svh"
module ccpcs_prescaler
  import ccpcs_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       timer_ev,
  input  wire logic       wdt_ev,
  input  wire logic       prescaler_assign,
  input  wire logic [2:0] prescale_rate,
  output logic            timer_inc,
  output logic            wdt_inc
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  wire        src_ev  = prescaler_assign ? wdt_ev : timer_ev;
  // timer divides by 2^(n+1), watchdog by 2^n
  wire [7:0]  mask    = ccpcs_mask(prescale_rate, ~prescaler_assign);
  wire        div_out = src_ev & ((cnt_q & mask) == mask);

  assign cnt_d     = src_ev ? cnt_q + 8'h01 : cnt_q;
  assign timer_inc = prescaler_assign ? timer_ev : div_out;
  assign wdt_inc   = prescaler_assign ? div_out : wdt_ev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_q <= 8'h00;
    else cnt_q <= cnt_d;
  end
endmodule : ccpcs_prescaler

// *** hw/ccpcs_stack_mem.sv ***
// return address storage, registered read
`timescale 1ns/1ps
module ccpcs_stack_mem (
  input  wire logic        pclk,
  input  wire logic        we,
  input  wire logic [2:0]  waddr,
  input  wire logic [12:0] wdata,
  input  wire logic [2:0]  raddr,
  output logic      [12:0] rdata_q
);
  logic [12:0] mem [0:7];

  always_ff @(posedge pclk) begin
    if (we) mem[waddr] <= wdata;
    rdata_q <= mem[raddr];
  end
endmodule : ccpcs_stack_mem

// *** sim/ccpcs_monitor.sv ***
// port-level assertions for the core control block
`timescale 1ns/1ps
module ccpcs_monitor
  import ccpcs_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        por_rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input ccpcs_core_s      core_cmd,
  input wire logic        instr_tick,
  input wire logic        wdt_tick,
  input wire logic        ext_interrupt_pin,
  input wire logic [2:0]  change_pins,
  input wire logic        timer_overflow,
  input wire logic        conv_done,
  input wire logic [12:0] pc_q,
  input wire logic        int_taken_q,
  input wire logic        timer_inc_q,
  input wire logic        wdt_inc_q,
  input wire logic        pullup_disable_q,
  input ccpcs_trim_s      trim_q
);
  // ****************************************
  // apb and core steps
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence pcl_wr_s;
    psel && penable && pready && pwrite && paddr == 12'h008;
  endsequence
  sequence jump_s;
    core_cmd.jump && !core_cmd.call && !core_cmd.ret && !$past(core_cmd.ret) && !psel;
  endsequence
  ready_next_a: assert property (setup_s |=> pready)
    else $error("pready missing after setup");
  bad_index_a: assert property (setup_s ##0 paddr[9:2] == 8'h05 |=> pslverr)
    else $error("no error on unmapped index");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  pc_reset_a: assert property ($rose(presetn) |-> pc_q == 13'h0)
    else $error("pc not cleared by reset");
  pcl_load_a: assert property (pcl_wr_s |=> pc_q[7:0] == $past(pwdata[7:0]))
    else $error("pc low byte not loaded");
  jump_target_a: assert property (jump_s |=> pc_q == {2'h0, $past(core_cmd.target)})
    else $error("jump target wrong");
  trim_fast_a: assert property (trim_q.faster |-> !trim_q.slower)
    else $error("slower acts with faster");
  int_vector_a: assert property (int_taken_q |-> pc_q == 13'h0004)
    else $error("interrupt not vectored");
  int_single_a: assert property (int_taken_q |=> !int_taken_q)
    else $error("interrupt taken twice");
endmodule : ccpcs_monitor
bind ccpcs_top ccpcs_monitor i_ccpcs_monitor (.pclk, .presetn, .por_rstn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .core_cmd, .instr_tick, .wdt_tick, .ext_interrupt_pin, .change_pins,
  .timer_overflow, .conv_done, .pc_q, .int_taken_q, .timer_inc_q, .wdt_inc_q, .pullup_disable_q, .trim_q);

// *** sim/ccpcs_top_tb_top.sv ***
// register and program counter tests of the core control block
`timescale 1ns/1ps
module ccpcs_top_tb_top
  import ccpcs_pkg::*;
;
  logic        pclk = 0, presetn = 0, por_rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        instr_tick = 0, wdt_tick = 0, ext_interrupt_pin = 0, timer_overflow = 0, conv_done = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [2:0]  change_pins = '0;
  ccpcs_core_s core_cmd = '0;
  logic [31:0] prdata;
  logic        pready, pslverr, int_taken_q, timer_inc_q, wdt_inc_q, pullup_disable_q, er;
  logic [12:0] pc_q;
  ccpcs_trim_s trim_q;
  logic [7:0]  rd;
  int          mismatches = 0, samples_checked = 0, ti = 0, wi = 0;
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    if (timer_inc_q === 1'b1) ti++;
    if (wdt_inc_q === 1'b1) wi++;
  end
  ccpcs_top i_ccpcs_top (.pclk, .presetn, .por_rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .core_cmd, .instr_tick, .wdt_tick, .ext_interrupt_pin, .change_pins, .timer_overflow,
    .conv_done, .pc_q, .int_taken_q, .timer_inc_q, .wdt_inc_q, .pullup_disable_q, .trim_q);
  // ****************************************
  // tasks
  // ****************************************
  task print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  task check(input logic [12:0] seen, input logic [12:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {2'h0, idx, 2'h0}; pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) mismatches++;
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr
  // settle time covers the pin synchronisers
  task rdchk(input logic [7:0] idx, input logic [7:0] exp);
    repeat (3) @(posedge pclk);
    apb(1'b0, idx, 8'h00);
    check(13'(rd), 13'(exp));
  endtask : rdchk
  task core(input logic [15:0] c);
    @(posedge pclk) core_cmd <= c;
    @(posedge pclk) core_cmd <= '0;
    repeat (2) @(posedge pclk);
  endtask : core
  task ticks(input logic w, input int n);
    ti = 0; wi = 0;
    repeat (n) begin
      @(posedge pclk) begin instr_tick <= !w; wdt_tick <= w; end
      @(posedge pclk) begin instr_tick <= 1'b0; wdt_tick <= 1'b0; end
    end
    repeat (3) @(posedge pclk);
  endtask : ticks
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1; por_rstn <= 1'b1;
    @(negedge pclk);
    check(pc_q, 13'h0);
    check(13'(pullup_disable_q), 13'h1);
    rdchk(8'h81, 8'hff);
    rdchk(8'h8f, 8'h70);
    apb(1'b0, 8'h05, 8'h00);
    check(13'(er), 13'h1);
    wr(8'h81, 8'h08);
    @(posedge pclk);
    @(negedge pclk);
    check(13'(pullup_disable_q), 13'h0);
    ticks(1'b0, 5);
    check(13'(ti), 13'h5);
    for (int k = 0; k < 8; k++) begin
      wr(8'h81, 8'(k));
      ticks(1'b0, 4 << k);
      check(13'(ti), 13'h2);
      wr(8'h81, 8'(8 + k));
      ticks(1'b1, 2 << k);
      check(13'(wi), 13'h2);
    end
    wr(8'h81, 8'h38);
    ti = 0;
    @(posedge pclk) ext_interrupt_pin <= 1'b1;
    @(posedge pclk) ext_interrupt_pin <= 1'b0;
    repeat (4) @(posedge pclk);
    check(13'(ti), 13'h1);
    wr(8'h0b, 8'h00);
    wr(8'h81, 8'h48);
    @(posedge pclk) timer_overflow <= 1'b1;
    @(posedge pclk) timer_overflow <= 1'b0;
    rdchk(8'h0b, 8'h04);
    wr(8'h0b, 8'h00);
    rdchk(8'h0b, 8'h00);
    @(posedge pclk) ext_interrupt_pin <= 1'b1;
    rdchk(8'h0b, 8'h02);
    wr(8'h0b, 8'h00);
    @(posedge pclk) ext_interrupt_pin <= 1'b0;
    rdchk(8'h0b, 8'h00);
    @(posedge pclk) change_pins <= 3'h2;
    rdchk(8'h0b, 8'h01);
    wr(8'h0b, 8'h00);
    @(posedge pclk) conv_done <= 1'b1;
    @(posedge pclk) conv_done <= 1'b0;
    rdchk(8'h0c, 8'h40);
    wr(8'h0c, 8'h00);
    wr(8'h0a, 8'h1f);
    wr(8'h02, 8'h34);
    @(negedge pclk);
    check(pc_q, 13'h1f34);
    rdchk(8'h02, 8'h34);
    core(16'h27ff);
    check(pc_q, 13'h07ff);
    @(posedge pclk) timer_overflow <= 1'b1;
    @(posedge pclk) timer_overflow <= 1'b0;
    wr(8'h0b, 8'h24);
    core(16'h8000);
    check(pc_q, 13'h0800);
    wr(8'h0b, 8'ha4);
    core(16'h8000);
    check(pc_q, 13'h0004);
    rdchk(8'h0b, 8'h24);
    core(16'h1800);
    check(pc_q, 13'h0800);
    rdchk(8'h0b, 8'ha4);
    wr(8'h0b, 8'h80);
    wr(8'h8c, 8'h40);
    @(posedge pclk) conv_done <= 1'b1;
    @(posedge pclk) conv_done <= 1'b0;
    core(16'h8000);
    check(pc_q, 13'h0801);
    wr(8'h0b, 8'hc0);
    core(16'h8000);
    check(pc_q, 13'h0004);
    wr(8'h0b, 8'h00);
    wr(8'h0c, 8'h00);
    core(16'h2000);
    for (int i = 1; i < 10; i++) core(16'h4000 | 16'(i * 8));
    for (int j = 0; j < 9; j++) begin
      core(16'h1000);
      check(pc_q, 13'(((j == 8) ? 8 : 8 - j) * 8 + 1));
    end
    rdchk(8'h0a, 8'h1f);
    wr(8'h8f, 8'hfc);
    @(posedge pclk);
    @(negedge pclk);
    check(13'(trim_q), 13'h3e);
    rdchk(8'h8f, 8'hfc);
    wr(8'h8e, 8'h02);
    @(posedge pclk) presetn <= 1'b0;
    @(posedge pclk) presetn <= 1'b1;
    rdchk(8'h8e, 8'h02);
    check(pc_q, 13'h0);
    @(posedge pclk) por_rstn <= 1'b0;
    @(posedge pclk) por_rstn <= 1'b1;
    rdchk(8'h8e, 8'h00);
    print_verdict;
  end
  // hang guard, well past the longest expected run
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    print_verdict;
  end
endmodule : ccpcs_top_tb_top
